// ===== src/synth_routing_lock_config.sv
`timescale 1ns/1ns
// Summary of operation
// - Ratio register: denominator low, numerator high
// - Rate equals base times multiplier times eight times ratio
// - Source-select byte, two bits per generator
// - Code 00 first loop, 01 second, rest reserved
// - Enable bit n gates generator n output
// - Lock-criterion byte, two bits per loop
// - Lock only after error stays under bound
// - Four-byte frequency trim register with reset default
// - Trim is signed, shared by all generators
// - Base frequency is taken directly in hertz
module synth_routing_lock_config #(
    parameter logic [31:0] LONG_CYCLES  = synth_cfg_pkg::LONG_CYCLES,
    parameter logic [31:0] SHORT_CYCLES = synth_cfg_pkg::SHORT_CYCLES
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        nrst,
    // Register port from the serial host interface
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [7:0]       reg_rdata,
    // Neighbouring rate settings of the fourth generator
    input  wire logic [15:0] base_frequency_hz,
    input  wire logic [15:0] base_multiplier,
    // Loop phase error magnitudes
    input  wire logic [31:0] loop_a_phase_error_ns,
    input  wire logic [31:0] loop_b_phase_error_ns,
    // Fourth generator rate
    output logic [15:0]      fourth_gen_numerator,
    output logic [15:0]      fourth_gen_denominator,
    output logic [50:0]      fourth_gen_rate_product,
    // Generator routing and enables
    output logic [1:0]       gen0_source_select,
    output logic [1:0]       gen1_source_select,
    output logic [1:0]       gen2_source_select,
    output logic [1:0]       gen3_source_select,
    output logic [3:0]       gen_second_loop,
    output logic [3:0]       gen_route_valid,
    output logic [3:0]       gen_output_enable,
    // Lock indication
    output logic [1:0]       loop_a_lock_criterion,
    output logic [1:0]       loop_b_lock_criterion,
    output logic             first_tracking_loop_locked,
    output logic             second_tracking_loop_locked,
    // Global trim
    output logic signed [31:0] frequency_trim
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [31:0] ratio_q, ratio_d;
    logic [7:0]  select_q, select_d;
    logic [7:0]  enable_q, enable_d;
    logic [7:0]  criterion_q, criterion_d;
    logic [31:0] trim_q, trim_d;
    logic [7:0]  rdata_q, rdata_d;

    always_comb begin
        ratio_d     = ratio_q;
        select_d    = select_q;
        enable_d    = enable_q;
        criterion_d = criterion_q;
        trim_d      = trim_q;
        if (reg_write) begin
            // Lowest address carries the most significant byte
            for (int k = 0; k < synth_cfg_pkg::WIDE_BYTES; k++) begin
                if (reg_addr == synth_cfg_pkg::RATIO_BASE + 8'(k)) begin
                    ratio_d[31 - 8 * k -: 8] = reg_wdata;
                end
                if (reg_addr == synth_cfg_pkg::TRIM_BASE + 8'(k)) begin
                    trim_d[31 - 8 * k -: 8] = reg_wdata;
                end
            end
            if (reg_addr == synth_cfg_pkg::SELECT_ADDR) begin
                select_d = reg_wdata;
            end
            if (reg_addr == synth_cfg_pkg::ENABLE_ADDR) begin
                enable_d = reg_wdata;
            end
            if (reg_addr == synth_cfg_pkg::CRITERION_ADDR) begin
                criterion_d = reg_wdata;
            end
        end
    end

    // New values drive the field outputs on the edge that takes the write; the rate product follows one edge later
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ratio_q     <= synth_cfg_pkg::RATIO_RESET;
            select_q    <= synth_cfg_pkg::SELECT_RESET;
            enable_q    <= synth_cfg_pkg::ENABLE_RESET;
            criterion_q <= synth_cfg_pkg::CRITERION_RESET;
            trim_q      <= synth_cfg_pkg::TRIM_RESET;
        end else begin
            ratio_q     <= ratio_d;
            select_q    <= select_d;
            enable_q    <= enable_d;
            criterion_q <= criterion_d;
            trim_q      <= trim_d;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Unmapped addresses read as zero; data holds between reads
    always_comb begin
        rdata_d = rdata_q;
        if (reg_read) begin
            rdata_d = 8'h00;
            for (int k = 0; k < synth_cfg_pkg::WIDE_BYTES; k++) begin
                if (reg_addr == synth_cfg_pkg::RATIO_BASE + 8'(k)) begin
                    rdata_d = ratio_q[31 - 8 * k -: 8];
                end
                if (reg_addr == synth_cfg_pkg::TRIM_BASE + 8'(k)) begin
                    rdata_d = trim_q[31 - 8 * k -: 8];
                end
            end
            if (reg_addr == synth_cfg_pkg::SELECT_ADDR) begin
                rdata_d = select_q;
            end
            if (reg_addr == synth_cfg_pkg::ENABLE_ADDR) begin
                rdata_d = enable_q;
            end
            if (reg_addr == synth_cfg_pkg::CRITERION_ADDR) begin
                rdata_d = criterion_q;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // Fourth generator rate
    // ------------------------------------------------------------
    // Product is the rate times the denominator; the divide is left to the
    // synthesizer so no wide divider sits in this block
    logic [50:0] product_q, product_d;

    always_comb begin
        product_d = 51'(base_frequency_hz) * 51'(base_multiplier)
                  * 51'(synth_cfg_pkg::SYNTH_MULT)
                  * 51'(ratio_q[synth_cfg_pkg::NUMER_LSB +: synth_cfg_pkg::RATIO_W]);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            product_q <= 51'h0;
        end else begin
            product_q <= product_d;
        end
    end

    assign fourth_gen_rate_product = product_q;
    assign fourth_gen_numerator    = ratio_q[synth_cfg_pkg::NUMER_LSB +: synth_cfg_pkg::RATIO_W];
    assign fourth_gen_denominator  = ratio_q[synth_cfg_pkg::DENOM_LSB +: synth_cfg_pkg::RATIO_W];

    // ------------------------------------------------------------
    // Routing and enables
    // ------------------------------------------------------------
    // Reserved codes clear the valid flag; the generator keeps its own
    // last good source rather than guessing one here
    genvar g;
    generate
        for (g = 0; g < synth_cfg_pkg::GEN_COUNT; g++) begin : gen_route
            logic [1:0] code;
            assign code = select_q[g * synth_cfg_pkg::SEL_W +: synth_cfg_pkg::SEL_W];
            assign gen_second_loop[g] = code == synth_cfg_pkg::LOOP_SECOND;
            assign gen_route_valid[g] = code == synth_cfg_pkg::LOOP_FIRST
                                     || code == synth_cfg_pkg::LOOP_SECOND;
            assign gen_output_enable[g] = enable_q[g];
        end
    endgenerate

    assign gen0_source_select = select_q[1:0];
    assign gen1_source_select = select_q[3:2];
    assign gen2_source_select = select_q[5:4];
    assign gen3_source_select = select_q[7:6];
    assign frequency_trim     = signed'(trim_q);

    // ------------------------------------------------------------
    // Lock qualification
    // ------------------------------------------------------------
    assign loop_a_lock_criterion = criterion_q[0 +: synth_cfg_pkg::CRIT_W];
    assign loop_b_lock_criterion = criterion_q[synth_cfg_pkg::LOOP_B_LSB +: synth_cfg_pkg::CRIT_W];

    lock_qualifier #(
        .LONG_CYCLES  (LONG_CYCLES),
        .SHORT_CYCLES (SHORT_CYCLES)
    ) u_loop_a (
        .clock          (clock),
        .nrst           (nrst),
        .criterion      (loop_a_lock_criterion),
        .phase_error_ns (loop_a_phase_error_ns),
        .locked         (first_tracking_loop_locked)
    );

    lock_qualifier #(
        .LONG_CYCLES  (LONG_CYCLES),
        .SHORT_CYCLES (SHORT_CYCLES)
    ) u_loop_b (
        .clock          (clock),
        .nrst           (nrst),
        .criterion      (loop_b_lock_criterion),
        .phase_error_ns (loop_b_phase_error_ns),
        .locked         (second_tracking_loop_locked)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_write(logic [7:0] a);
        reg_write && reg_addr == a;
    endsequence

    sequence s_read(logic [7:0] a);
        reg_read && reg_addr == a && !reg_write;
    endsequence

    a_ratio_low_byte: assert property (
        s_write(synth_cfg_pkg::RATIO_BASE + 8'h03)
        |=> fourth_gen_denominator[7:0] == $past(reg_wdata))
        else $error("denominator low byte not taken");

    a_ratio_readback: assert property (
        s_write(synth_cfg_pkg::RATIO_BASE) ##1 s_read(synth_cfg_pkg::RATIO_BASE)
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("numerator high byte readback wrong");

    // Gated by the sampled reset so the release edge, where the product is
    // still cleared, is not held against inputs of the cycle before
    a_rate_product: assert property (
        nrst |=> fourth_gen_rate_product == 51'($past(base_frequency_hz))
            * 51'($past(base_multiplier)) * 51'h8 * 51'($past(fourth_gen_numerator)))
        else $error("fourth generator rate product wrong");

    a_select_write: assert property (
        s_write(synth_cfg_pkg::SELECT_ADDR)
        |=> gen3_source_select == $past(reg_wdata[7:6])
            && gen0_source_select == $past(reg_wdata[1:0]))
        else $error("source select not applied");

    a_second_loop_route: assert property (
        s_write(synth_cfg_pkg::SELECT_ADDR) ##0 reg_wdata[3:2] == 2'h1
        |=> gen_second_loop[1] && gen_route_valid[1])
        else $error("code 01 did not route the second loop");

    a_reserved_route: assert property (
        s_write(synth_cfg_pkg::SELECT_ADDR) ##0 reg_wdata[1]
        |=> !gen_route_valid[0] && !gen_second_loop[0])
        else $error("reserved code left generator 0 routed");

    a_enable_write: assert property (
        s_write(synth_cfg_pkg::ENABLE_ADDR)
        |=> gen_output_enable == $past(reg_wdata[3:0]))
        else $error("output enables not applied");

    a_enable_held: assert property (
        !(reg_write && reg_addr == synth_cfg_pkg::ENABLE_ADDR)
        |=> $stable(gen_output_enable))
        else $error("output enables changed without a write");

    a_criterion_write: assert property (
        s_write(synth_cfg_pkg::CRITERION_ADDR)
        |=> loop_b_lock_criterion == $past(reg_wdata[3:2])
            && loop_a_lock_criterion == $past(reg_wdata[1:0]))
        else $error("criterion not applied");

    // The qualifier sees the new field one edge after the write, so lock
    // falls on the second edge
    a_criterion_restart: assert property (
        s_write(synth_cfg_pkg::CRITERION_ADDR) ##0 reg_wdata[1:0] != loop_a_lock_criterion
        |=> ##1 !first_tracking_loop_locked)
        else $error("lock held across a criterion change");

    a_trim_write: assert property (
        s_write(synth_cfg_pkg::TRIM_BASE)
        |=> frequency_trim[31:24] == $past(reg_wdata))
        else $error("trim top byte not taken");

    a_trim_low_byte: assert property (
        s_write(synth_cfg_pkg::TRIM_BASE + 8'h03)
        |=> frequency_trim[7:0] == $past(reg_wdata))
        else $error("trim low byte not taken");

    a_trim_signed: assert property (
        s_write(synth_cfg_pkg::TRIM_BASE) ##0 reg_wdata[7] |=> frequency_trim < 0)
        else $error("trim not read as signed");

    a_unmapped_zero: assert property (
        reg_read && reg_addr > synth_cfg_pkg::TRIM_BASE + 8'h03
        |=> reg_rdata == 8'h00 ##1 ($past(reg_read) || $stable(reg_rdata)))
        else $error("unmapped read not zero or data not held");

    a_unmapped_write: assert property (
        reg_write && (reg_addr < synth_cfg_pkg::RATIO_BASE
                      || reg_addr > synth_cfg_pkg::TRIM_BASE + 8'h03)
        |=> $stable(fourth_gen_numerator) && $stable(fourth_gen_denominator)
            && $stable(frequency_trim) && $stable(gen_output_enable))
        else $error("write to an unmapped address changed a register");

endmodule : synth_routing_lock_config

// ===== src/synth_cfg_pkg.sv
package synth_cfg_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] RATIO_BASE     = 8'h6C;
    localparam logic [7:0] SELECT_ADDR    = 8'h70;
    localparam logic [7:0] ENABLE_ADDR    = 8'h71;
    localparam logic [7:0] CRITERION_ADDR = 8'h72;
    localparam logic [7:0] TRIM_BASE      = 8'h73;
    localparam int         WIDE_BYTES     = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RATIO_RESET     = 32'h00010001;
    localparam logic [7:0]  SELECT_RESET    = 8'hE4;
    localparam logic [7:0]  ENABLE_RESET    = 8'h03;
    localparam logic [7:0]  CRITERION_RESET = 8'h00;
    localparam logic [31:0] TRIM_RESET      = 32'h046AAAAB;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int DENOM_LSB  = 0;
    localparam int NUMER_LSB  = 16;
    localparam int RATIO_W    = 16;
    localparam int SEL_W      = 2;
    localparam int GEN_COUNT  = 4;
    localparam int CRIT_W     = 2;
    localparam int LOOP_B_LSB = 2;
    localparam int PRODUCT_W  = 51;
    localparam logic [3:0] SYNTH_MULT = 4'h8;

    // ------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LOOP_FIRST  = 2'h0,
        LOOP_SECOND = 2'h1,
        LOOP_RSV_A  = 2'h2,
        LOOP_RSV_B  = 2'h3
    } loop_sel_e;

    typedef enum logic [1:0] {
        CRIT_36US_10S = 2'h0,
        CRIT_1US_1S   = 2'h1,
        CRIT_10US_1S  = 2'h2,
        CRIT_10US_10S = 2'h3
    } criterion_e;

    typedef enum logic [1:0] {
        QUAL_IDLE    = 2'h0,
        QUAL_RUNNING = 2'h1,
        QUAL_LOCKED  = 2'h3
    } qual_state_e;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint CLOCK_HZ          = 125000000;
    localparam longint LONG_INTERVAL_S   = 10;
    localparam longint SHORT_INTERVAL_S  = 1;
    localparam logic [31:0] LONG_CYCLES  = 32'(LONG_INTERVAL_S * CLOCK_HZ);
    localparam logic [31:0] SHORT_CYCLES = 32'(SHORT_INTERVAL_S * CLOCK_HZ);
    localparam longint BOUND_36_US       = 36;
    localparam longint BOUND_10_US       = 10;
    localparam longint BOUND_1_US        = 1;
    localparam longint NS_PER_US         = 1000;
    localparam logic [31:0] BOUND_36_NS  = 32'(BOUND_36_US * NS_PER_US);
    localparam logic [31:0] BOUND_10_NS  = 32'(BOUND_10_US * NS_PER_US);
    localparam logic [31:0] BOUND_1_NS   = 32'(BOUND_1_US * NS_PER_US);

endpackage : synth_cfg_pkg

// ===== src/lock_qualifier.sv
`timescale 1ns/1ns
module lock_qualifier #(
    parameter logic [31:0] LONG_CYCLES  = synth_cfg_pkg::LONG_CYCLES,
    parameter logic [31:0] SHORT_CYCLES = synth_cfg_pkg::SHORT_CYCLES
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        nrst,
    // Criterion and measurement
    input  wire logic [1:0]  criterion,
    input  wire logic [31:0] phase_error_ns,
    // Indication
    output logic             locked
);

    synth_cfg_pkg::qual_state_e state_q, state_d;
    logic [31:0] count_q, count_d;
    logic [1:0]  crit_q, crit_d;
    logic [31:0] bound;
    logic [31:0] interval;
    logic        good;

    // ------------------------------------------------------------
    // Criterion decode
    // ------------------------------------------------------------
    always_comb begin
        case (synth_cfg_pkg::criterion_e'(criterion))
            synth_cfg_pkg::CRIT_36US_10S: begin
                bound    = synth_cfg_pkg::BOUND_36_NS;
                interval = LONG_CYCLES;
            end
            synth_cfg_pkg::CRIT_1US_1S: begin
                bound    = synth_cfg_pkg::BOUND_1_NS;
                interval = SHORT_CYCLES;
            end
            synth_cfg_pkg::CRIT_10US_1S: begin
                bound    = synth_cfg_pkg::BOUND_10_NS;
                interval = SHORT_CYCLES;
            end
            default: begin
                bound    = synth_cfg_pkg::BOUND_10_NS;
                interval = LONG_CYCLES;
            end
        endcase
    end

    assign good = phase_error_ns < bound;

    // ------------------------------------------------------------
    // Qualification
    // ------------------------------------------------------------
    // A new criterion restarts the interval so lock never rests on the old bound
    always_comb begin
        state_d = state_q;
        count_d = count_q;
        crit_d  = criterion;
        if (!good || criterion != crit_q) begin
            state_d = synth_cfg_pkg::QUAL_IDLE;
            count_d = 32'h00000000;
        end else begin
            case (state_q)
                synth_cfg_pkg::QUAL_IDLE: begin
                    state_d = synth_cfg_pkg::QUAL_RUNNING;
                    count_d = 32'h00000001;
                end
                synth_cfg_pkg::QUAL_RUNNING: begin
                    count_d = count_q + 32'h00000001;
                    if (count_d >= interval) begin
                        state_d = synth_cfg_pkg::QUAL_LOCKED;
                    end
                end
                synth_cfg_pkg::QUAL_LOCKED: begin
                    state_d = synth_cfg_pkg::QUAL_LOCKED;
                end
                default: begin
                    state_d = synth_cfg_pkg::QUAL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q <= synth_cfg_pkg::QUAL_IDLE;
            count_q <= 32'h00000000;
            crit_q  <= 2'h0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            crit_q  <= crit_d;
        end
    end

    assign locked = state_q == synth_cfg_pkg::QUAL_LOCKED;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_bad_drops_lock: assert property (@(posedge clock) disable iff (!nrst)
        !good |=> !locked)
        else $error("lock held after phase error exceeded bound");

    a_lock_after_interval: assert property (@(posedge clock) disable iff (!nrst)
        $rose(locked) |-> $past(count_q) + 32'h00000001 >= $past(interval))
        else $error("lock reported before interval elapsed");

endmodule : lock_qualifier

// ===== testbench/synth_routing_lock_config_test.sv
`timescale 1ns/1ns
module synth_routing_lock_config_test;

    // ------------------------------------------------------------
    // Short qualification intervals keep the run brief
    // ------------------------------------------------------------
    localparam logic [31:0] LONG_SIM  = 32'h14;
    localparam logic [31:0] SHORT_SIM = 32'h5;

    logic        clock;
    logic        nrst;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_write;
    logic        reg_read;
    logic [7:0]  reg_rdata;
    logic [15:0] base_hz;
    logic [15:0] base_mult;
    logic [31:0] a_err;
    logic [31:0] b_err;
    logic [15:0] numer;
    logic [15:0] denom;
    logic [50:0] product;
    logic [1:0]  sel0;
    logic [1:0]  sel1;
    logic [1:0]  sel2;
    logic [1:0]  sel3;
    logic [3:0]  second_loop;
    logic [3:0]  route_valid;
    logic [3:0]  out_en;
    logic [1:0]  crit_a;
    logic [1:0]  crit_b;
    logic        locked_a;
    logic        locked_b;
    logic signed [31:0] trim;
    logic [7:0]  model [0:10];
    int          n_fail;
    int          tests_run;
    int          seed;

    synth_routing_lock_config #(.LONG_CYCLES(LONG_SIM), .SHORT_CYCLES(SHORT_SIM))
        synth_routing_lock_config_inst (
        .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .base_frequency_hz(base_hz), .base_multiplier(base_mult),
        .loop_a_phase_error_ns(a_err), .loop_b_phase_error_ns(b_err),
        .fourth_gen_numerator(numer), .fourth_gen_denominator(denom),
        .fourth_gen_rate_product(product), .gen0_source_select(sel0),
        .gen1_source_select(sel1), .gen2_source_select(sel2), .gen3_source_select(sel3),
        .gen_second_loop(second_loop), .gen_route_valid(route_valid),
        .gen_output_enable(out_en), .loop_a_lock_criterion(crit_a),
        .loop_b_lock_criterion(crit_b), .first_tracking_loop_locked(locked_a),
        .second_tracking_loop_locked(locked_b), .frequency_trim(trim));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task end_of_test;
        if (n_fail == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------
    // Register port, one byte per request
    // ------------------------------------------------------------
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        if (a >= 8'h6C && a <= 8'h76) model[a - 8'h6C] = d;
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        check("reg_rdata", {56'h0, reg_rdata}, {56'h0, exp});
    endtask : rd

    task reset_model;
        {model[0], model[1], model[2], model[3]} = synth_cfg_pkg::RATIO_RESET;
        model[4] = synth_cfg_pkg::SELECT_RESET;
        model[5] = synth_cfg_pkg::ENABLE_RESET;
        model[6] = synth_cfg_pkg::CRITERION_RESET;
        {model[7], model[8], model[9], model[10]} = synth_cfg_pkg::TRIM_RESET;
    endtask : reset_model

    // Outputs first, then every mapped byte read back
    task check_all;
        logic [1:0] s;
        #1;
        check("numerator", numer, {model[0], model[1]});
        check("denominator", denom, {model[2], model[3]});
        check("source_select", {sel3, sel2, sel1, sel0}, model[4]);
        for (int g = 0; g < 4; g++) begin
            s = model[4][2*g +: 2];
            check("second_loop", second_loop[g], s == 2'h1);
            check("route_valid", route_valid[g], !s[1]);
        end
        check("output_enable", out_en, model[5][3:0]);
        check("criterion", {crit_b, crit_a}, model[6][3:0]);
        check("trim", trim[31:0], {model[7], model[8], model[9], model[10]});
        for (int i = 0; i < 11; i++) rd(8'h6C + 8'(i), model[i]);
    endtask : check_all

    function automatic logic [31:0] bound(input logic [1:0] c);
        return c == 2'h0 ? synth_cfg_pkg::BOUND_36_NS :
               c == 2'h1 ? synth_cfg_pkg::BOUND_1_NS : synth_cfg_pkg::BOUND_10_NS;
    endfunction : bound

    function automatic int interval(input logic [1:0] c);
        return (c == 2'h0 || c == 2'h3) ? int'(LONG_SIM) : int'(SHORT_SIM);
    endfunction : interval

    // One loop held under the bound (just under for codes 0 and 1, random below it for 2 and 3), the other exactly at it
    task lock_case(input logic [1:0] c);
        logic [31:0] b;
        logic [31:0] g;
        b = bound(c);
        g = c[1] ? 32'($unsigned($random(seed))) % b : b - 32'h1;
        wr(synth_cfg_pkg::CRITERION_ADDR, {4'h0, c, c});
        @(posedge clock);
        a_err <= c[0] ? b : g;
        b_err <= c[0] ? g : b;
        repeat (interval(c) - 1) @(posedge clock);
        #1;
        check("locked_early", {locked_a, locked_b}, 2'b00);
        repeat (2) @(posedge clock);
        #1;
        check("locked", {locked_a, locked_b}, c[0] ? 2'b01 : 2'b10);
        // Same bound, longer interval: a rewrite must still restart qualification
        if (c == 2'h2) begin
            wr(synth_cfg_pkg::CRITERION_ADDR, 8'hFF);
            @(posedge clock);
            #1;
            check("lock_restart", {locked_a, locked_b}, 2'b00);
        end
        @(posedge clock);
        a_err <= b;
        b_err <= b;
        repeat (2) @(posedge clock);
        #1;
        check("lock_lost", {locked_a, locked_b}, 2'b00);
        a_err <= 32'hFFFFFFFF;
        b_err <= 32'hFFFFFFFF;
    endtask : lock_case

    initial begin
        seed = 19;
        n_fail = 0;
        tests_run = 0;
        nrst = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        base_hz = 16'h9C40;
        base_mult = 16'h0798;
        a_err = 32'hFFFFFFFF;
        b_err = 32'hFFFFFFFF;
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        reset_model();
        check_all();
        wr(synth_cfg_pkg::SELECT_ADDR, 8'h1B);
        wr(synth_cfg_pkg::ENABLE_ADDR, 8'hFF);
        check_all();
        wr(synth_cfg_pkg::SELECT_ADDR, 8'h64);
        check_all();
        repeat (20) begin
            wr(8'h6C + 8'($unsigned($random(seed)) % 11), 8'($random(seed)));
            check_all();
        end
        wr(8'h77, 8'h5A);
        wr(8'h6B, 8'hA5);
        wr(synth_cfg_pkg::TRIM_BASE, 8'hC3);
        wr(synth_cfg_pkg::TRIM_BASE + 8'h03, 8'h5A);
        wr(synth_cfg_pkg::RATIO_BASE + 8'h03, 8'hED);
        check_all();
        rd(8'h77, 8'h00);
        rd(8'h00, 8'h00);
        // Write then read the same byte on consecutive cycles
        @(posedge clock);
        reg_addr  <= synth_cfg_pkg::RATIO_BASE;
        reg_wdata <= 8'h3C;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        reg_read  <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        model[0] = 8'h3C;
        #1;
        check("readback", {56'h0, reg_rdata}, 64'h3C);
        for (int k = 0; k < 8; k++) begin
            wr(synth_cfg_pkg::RATIO_BASE, k == 0 ? 8'hFF : 8'($random(seed)));
            wr(synth_cfg_pkg::RATIO_BASE + 8'h1, k == 0 ? 8'hFF : 8'($random(seed)));
            base_hz <= k == 0 ? 16'hFFFF : 16'($random(seed));
            base_mult <= k == 0 ? 16'hFFFF : 16'($random(seed));
            repeat (2) @(posedge clock);
            #1;
            check("rate_product", product, 51'(base_hz) * 51'(base_mult) * 51'(8)
                  * 51'({model[0], model[1]}));
        end
        for (int c = 0; c < 4; c++) lock_case(2'(c));
        nrst <= 1'b0;
        @(posedge clock);
        #1;
        check("reset_product", product, 51'h0);
        nrst <= 1'b1;
        reset_model();
        check_all();
        end_of_test();
    end

endmodule : synth_routing_lock_config_test
